// ---- rtl/timer_clk_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Register index times four is the Avalon byte address.
// Notes: Definitions only.
`ifndef TIMER_CLK_DEFINES_SVH
`define TIMER_CLK_DEFINES_SVH
// ==========================================================
// Register indexes
`define IDX_PROC_CLK 8'h30
`define IDX_TIMER_CLK 8'h31
`define IDX_CLK_OUT 8'h32
`define IDX_RELOAD_LO 8'h40
`define IDX_RELOAD_HI 8'h41
`define IDX_STATUS 8'hff
// ==========================================================
// Reset values
`define TIMER_CLK_RST 8'h8f
`define CLK_OUT_RST 2'h0
`define RELOAD_RST 12'h000
`define STATUS_RST 8'h10
`define BOOT_ADDR 16'h0000
// ==========================================================
// Field positions
`define PROC_SEL_BIT 0
`define STAT_GIE_BIT 7
`define STAT_WDR_BIT 5
`define STAT_POR_BIT 4
`define STAT_SLEEP_BIT 3
`define STAT_STOP_BIT 0
// ==========================================================
// Timing
`define REF_CLK_HZ 40000000
`define POR_HOLD_MS 20
`define POR_HOLD_CYCLES ((`POR_HOLD_MS * `REF_CLK_HZ) / 1000)
`define OSC_RECOVER_SLOW 3
`define PROC_DIV 4'h8
`define TICK_US 1024
`define CAP_ASSUMED_MHZ 4
`define TICK_CAP_COUNT (`TICK_US * `CAP_ASSUMED_MHZ)
`endif

// ---- rtl/timer_clk_pkg.sv ----
// Purpose: Types shared by the timer clock and reset control.
// Assumes: Constants live in timer_clk_defines.svh.
// Notes: None.
package timer_clk_pkg;
  typedef enum logic [1:0] {
    SRC_OSC24 = 2'b00,
    SRC_EXT = 2'b01,
    SRC_SLOW = 2'b10,
    SRC_ALT = 2'b11
  } clk_src_e;
  typedef enum logic [1:0] {
    PWR_BOOT = 2'b00,
    PWR_RUN = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_RECOVER = 2'b11
  } pwr_state_e;
  typedef struct packed {
    logic [1:0] capDiv;
    clk_src_e capSel;
    logic [1:0] intDiv;
    clk_src_e intSel;
  } timer_cfg_s;
  typedef struct packed {
    logic osc24;
    logic ext;
    logic slow;
  } clk_pins_s;
endpackage

// ---- rtl/timer_clock_and_reset_control.sv ----
// Purpose: Timer clock selection, interval counter, clock output and reset/sleep status.
// Assumes: Oscillator and external clock arrive as pins; their edges become ref_clk ticks.
// Notes: sys_rst is the power-up reset; watchdogResetEvent is a same-clock pulse.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "timer_clk_defines.svh"
`default_nettype none

// ==========================================================
// Tick divider
module tick_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcTick,
  input wire logic [3:0] divisor,
  output logic tick
);
  logic [3:0] count_ff;
  logic tick_ff;
  logic atEnd;

  assign atEnd = (count_ff >= (divisor - 4'h1));

  // A shrinking divisor cannot strand the count, since >= catches it.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= 4'h0;
    end else if (srcTick) begin
      count_ff <= atEnd ? 4'h0 : count_ff + 4'h1;
    end
  end

  // One tick per divisor source edges.
  always_ff @(posedge clk) begin
    tick_ff <= !rst && srcTick && atEnd;
  end

  assign tick = tick_ff;
endmodule

// ==========================================================
// Top
module timer_clock_and_reset_control #(
  parameter int unsigned PorHoldCycles = `POR_HOLD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire timer_clk_pkg::clk_pins_s clkPins,
  input wire logic watchdogResetEvent,
  input wire logic globalIrqEnable,
  input wire logic irqPending,
  output logic captureTimerClkTick,
  output logic intervalTimerClkTick,
  output logic intervalTick1024,
  output logic intervalIrq,
  output logic clockOutputPin,
  output logic processorClkTick,
  output logic processorHold,
  output logic internalOscRun,
  output logic [15:0] bootAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  timer_clk_pkg::clk_pins_s pinMeta_ff, pinSync_ff, pinLast_ff;
  timer_clk_pkg::timer_cfg_s timerCfg_ff;
  timer_clk_pkg::pwr_state_e state_ff;
  logic waitReq_ff, procSel_ff, wdFlag_ff, porFlag_ff, sleep_ff, stop_ff;
  logic oscRun_ff, hold_ff, irq_ff, tick1024_ff, clock_output_pin_ff, procLvl_ff;
  logic [1:0] clkOutCfg_ff, recCnt_ff;
  logic [7:0] reloadStage_ff, rdMux;
  logic [11:0] reload_ff, intCnt_ff, tickCnt_ff;
  logic [19:0] porCnt_ff;
  logic [31:0] readdata_ff;
  logic [15:0] bootAddr_ff;
  logic rise24, riseExt, rise32, wdReset, regRst, wrEn;
  logic capSrcTick, intSrcTick, procSrcTick, capTick, intTick, procTick, procHalfTick;
  logic [3:0] capDivisor, intDivisor;
  logic [7:0] regIdx, wdata;

  // ==========================================================
  // Pin synchronisers and edge detect
  // Edges are taken from the second stage only; 24 MHz seen at 40 MHz aliases.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      pinLast_ff <= '0;
    end else begin
      pinMeta_ff <= clkPins;
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end

  assign rise24 = pinSync_ff.osc24 && !pinLast_ff.osc24 && oscRun_ff;
  assign riseExt = pinSync_ff.ext && !pinLast_ff.ext;
  assign rise32 = pinSync_ff.slow && !pinLast_ff.slow;

  // Watchdog resets are ignored while the power flag stands.
  assign wdReset = watchdogResetEvent && !porFlag_ff;
  assign regRst = sys_rst || wdReset;

  // ==========================================================
  // Avalon slave: waitrequest high one cycle, then one cycle low
  assign regIdx = avs_address[9:2];
  assign wdata = avs_writedata[7:0];
  assign wrEn = avs_write && !waitReq_ff && avs_byteenable[0] && (avs_address[1:0] == 2'b00);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= !((avs_read || avs_write) && waitReq_ff);
    end
  end

  // Read mux; unmapped indexes read as zero.
  always_comb begin
    rdMux = 8'h00;
    case (regIdx)
      `IDX_PROC_CLK: rdMux = {7'h00, procSel_ff};
      `IDX_TIMER_CLK: rdMux = timerCfg_ff;
      `IDX_CLK_OUT: rdMux = {6'h00, clkOutCfg_ff};
      `IDX_RELOAD_LO: rdMux = reload_ff[7:0];
      `IDX_RELOAD_HI: rdMux = {4'h0, reload_ff[11:8]};
      `IDX_STATUS: rdMux = {globalIrqEnable, 1'b0, wdFlag_ff, porFlag_ff, sleep_ff, 2'b00, stop_ff};
      default: rdMux = 8'h00;
    endcase
    if (avs_address[1:0] != 2'b00) begin
      rdMux = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      readdata_ff <= 32'h00000000;
    end else if (avs_read && waitReq_ff) begin
      readdata_ff <= {24'h000000, rdMux};
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      timerCfg_ff <= `TIMER_CLK_RST;
      clkOutCfg_ff <= `CLK_OUT_RST;
      procSel_ff <= 1'b0;
    end else begin
      if (wrEn && regIdx == `IDX_TIMER_CLK) begin
        timerCfg_ff <= wdata;
      end
      if (wrEn && regIdx == `IDX_CLK_OUT) begin
        clkOutCfg_ff <= wdata[1:0];
      end
      // Sleep entry overrides any write to the select bit.
      if (state_ff == timer_clk_pkg::PWR_RUN && sleep_ff) begin
        procSel_ff <= 1'b0;
      end else if (wrEn && regIdx == `IDX_PROC_CLK) begin
        procSel_ff <= wdata[`PROC_SEL_BIT];
      end
    end
  end

  // Low byte only stages; the high byte write commits both halves at once.
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      reloadStage_ff <= 8'(`RELOAD_RST);
      reload_ff <= `RELOAD_RST;
    end else if (wrEn && regIdx == `IDX_RELOAD_LO) begin
      reloadStage_ff <= wdata;
    end else if (wrEn && regIdx == `IDX_RELOAD_HI) begin
      reload_ff <= {wdata[3:0], reloadStage_ff};
    end
  end

  // ==========================================================
  // Status flags; hardware set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      porFlag_ff <= 1'(`STATUS_RST >> `STAT_POR_BIT);
      wdFlag_ff <= 1'b0;
    end else begin
      if (wdReset) begin
        wdFlag_ff <= 1'b1;
      end else if (wrEn && regIdx == `IDX_STATUS && !wdata[`STAT_WDR_BIT]) begin
        wdFlag_ff <= 1'b0;
      end
      if (wrEn && regIdx == `IDX_STATUS && !wdata[`STAT_POR_BIT]) begin
        porFlag_ff <= 1'b0;
      end
    end
  end

  // Sleep clears itself when the wake sequence ends; stop holds until reset.
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      sleep_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      if (wrEn && regIdx == `IDX_STATUS) begin
        sleep_ff <= wdata[`STAT_SLEEP_BIT];
      end else if (state_ff == timer_clk_pkg::PWR_RECOVER && rise32 &&
                   recCnt_ff == 2'(`OSC_RECOVER_SLOW - 1)) begin
        sleep_ff <= 1'b0;
      end
      if (wrEn && regIdx == `IDX_STATUS && wdata[`STAT_STOP_BIT]) begin
        stop_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Power sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= timer_clk_pkg::PWR_BOOT;
      porCnt_ff <= 20'h00000;
      recCnt_ff <= 2'h0;
      oscRun_ff <= 1'b1;
    end else if (wdReset) begin
      state_ff <= timer_clk_pkg::PWR_RUN;
      recCnt_ff <= 2'h0;
      oscRun_ff <= 1'b1;
    end else begin
      case (state_ff)
        timer_clk_pkg::PWR_BOOT: begin
          porCnt_ff <= porCnt_ff + 20'h00001;
          if (porCnt_ff == 20'(PorHoldCycles - 1)) begin
            state_ff <= timer_clk_pkg::PWR_RUN;
          end
        end
        timer_clk_pkg::PWR_RUN: begin
          if (sleep_ff) begin
            state_ff <= timer_clk_pkg::PWR_SLEEP;
            oscRun_ff <= 1'b0;
          end
        end
        timer_clk_pkg::PWR_SLEEP: begin
          if (irqPending) begin
            state_ff <= timer_clk_pkg::PWR_RECOVER;
            oscRun_ff <= 1'b1;
            recCnt_ff <= 2'h0;
          end
        end
        timer_clk_pkg::PWR_RECOVER: begin
          if (rise32) begin
            if (recCnt_ff == 2'(`OSC_RECOVER_SLOW - 1)) begin
              state_ff <= timer_clk_pkg::PWR_RUN;
            end else begin
              recCnt_ff <= recCnt_ff + 2'h1;
            end
          end
        end
        default: state_ff <= timer_clk_pkg::PWR_BOOT;
      endcase
    end
  end

  // Held cores restart at the boot address once released.
  always_ff @(posedge ref_clk) begin
    hold_ff <= sys_rst || wdReset || stop_ff || (state_ff != timer_clk_pkg::PWR_RUN);
    bootAddr_ff <= `BOOT_ADDR;
  end

  // ==========================================================
  // Clock sources and dividers
  always_comb begin
    case (timerCfg_ff.capSel)
      timer_clk_pkg::SRC_OSC24: capSrcTick = rise24;
      timer_clk_pkg::SRC_EXT: capSrcTick = riseExt;
      timer_clk_pkg::SRC_SLOW: capSrcTick = rise32;
      default: capSrcTick = 1'b0;
    endcase
    case (timerCfg_ff.intSel)
      timer_clk_pkg::SRC_OSC24: intSrcTick = rise24;
      timer_clk_pkg::SRC_EXT: intSrcTick = riseExt;
      timer_clk_pkg::SRC_SLOW: intSrcTick = rise32;
      default: intSrcTick = capTick;
    endcase
  end

  assign capDivisor = {1'b0, timerCfg_ff.capDiv, 1'b0} + 4'h2;
  assign intDivisor = {2'b00, timerCfg_ff.intDiv} + 4'h1;
  assign procSrcTick = procSel_ff ? riseExt : rise24;

  tick_divider capDivider (.clk(ref_clk), .rst(regRst), .srcTick(capSrcTick), .divisor(capDivisor), .tick(capTick));
  tick_divider intDivider (.clk(ref_clk), .rst(regRst), .srcTick(intSrcTick), .divisor(intDivisor), .tick(intTick));
  tick_divider procDivider (.clk(ref_clk), .rst(regRst), .srcTick(procSrcTick), .divisor(`PROC_DIV), .tick(procTick));
  // Half-period ticks so the pin copy of the processor clock runs at its full rate.
  tick_divider procHalfDivider (.clk(ref_clk), .rst(regRst), .srcTick(procSrcTick), .divisor(4'(`PROC_DIV >> 1)),
    .tick(procHalfTick));

  // ==========================================================
  // Interval counter, 1024 us tick and clock output
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      intCnt_ff <= `RELOAD_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= intTick && (intCnt_ff == 12'h000);
      if (intTick) begin
        intCnt_ff <= (intCnt_ff == 12'h000) ? reload_ff : intCnt_ff - 12'h001;
      end
    end
  end

  // Runs off the capture clock, so its period scales with that clock.
  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      tickCnt_ff <= 12'h000;
      tick1024_ff <= 1'b0;
    end else begin
      tick1024_ff <= capTick && (tickCnt_ff == 12'(`TICK_CAP_COUNT - 1));
      if (capTick) begin
        tickCnt_ff <= tickCnt_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (regRst) begin
      procLvl_ff <= 1'b0;
      clock_output_pin_ff <= 1'b0;
    end else begin
      // Toggling on half periods gives one rising edge per processor clock.
      procLvl_ff <= procLvl_ff ^ procHalfTick;
      case (clkOutCfg_ff)
        2'b00: clock_output_pin_ff <= pinSync_ff.osc24 && oscRun_ff;
        2'b01: clock_output_pin_ff <= pinSync_ff.ext;
        2'b10: clock_output_pin_ff <= pinSync_ff.slow;
        default: clock_output_pin_ff <= procLvl_ff;
      endcase
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitReq_ff;
  assign captureTimerClkTick = capTick;
  assign intervalTimerClkTick = intTick;
  assign intervalTick1024 = tick1024_ff;
  assign intervalIrq = irq_ff;
  assign clockOutputPin = clock_output_pin_ff;
  assign processorClkTick = procTick;
  assign processorHold = hold_ff;
  assign internalOscRun = oscRun_ff;
  assign bootAddr = bootAddr_ff;

  // ==========================================================
  // Checks
  logic [3:0] capSeen_ff;
  logic capKnown_ff;
  always_ff @(posedge ref_clk) begin
    if (regRst || (wrEn && regIdx == `IDX_TIMER_CLK)) begin
      capSeen_ff <= 4'h0;
      capKnown_ff <= 1'b0;
    end else if (capTick) begin
      capSeen_ff <= {3'h0, capSrcTick};
      capKnown_ff <= 1'b1;
    end else if (capSrcTick) begin
      capSeen_ff <= capSeen_ff + 4'h1;
    end
  end

  cap_ratio_a: assert property (capTick && capKnown_ff |-> capSeen_ff == capDivisor)
    else $error("Capture divide ratio wrong.");
  cap_slow_a: assert property (capTick && timerCfg_ff.capSel == timer_clk_pkg::SRC_SLOW && $stable(timerCfg_ff)
    |-> $past(rise32)) else $error("Capture tick without slow edge.");
  int_div_a: assert property (capTick && timerCfg_ff.intSel == timer_clk_pkg::SRC_ALT && timerCfg_ff.intDiv == 2'b00
    ##1 $stable(timerCfg_ff) |-> intTick) else $error("Interval undivided tick missing.");
  int_src_a: assert property (intTick && timerCfg_ff.intSel == timer_clk_pkg::SRC_ALT && $stable(timerCfg_ff)
    |-> $past(capTick)) else $error("Interval tick not from capture clock.");
  count_down_a: assert property (intTick && intCnt_ff != 12'h000 && !wdReset |=> intCnt_ff == $past(intCnt_ff) - 12'h001)
    else $error("Interval counter did not decrement.");
  reload_irq_a: assert property (intTick && intCnt_ff == 12'h000 && !wdReset |=> irq_ff && intCnt_ff == $past(reload_ff))
    else $error("Reload without interrupt.");
  reload_atomic_a: assert property (wrEn && regIdx == `IDX_RELOAD_LO |=> $stable(reload_ff) || $past(wdReset))
    else $error("Reload changed on low byte.");
  clk_out_a: assert property (clkOutCfg_ff == 2'b11 && $stable(clkOutCfg_ff) && !$past(wdReset)
    |-> clock_output_pin_ff == $past(procLvl_ff)) else $error("Clock output not processor clock.");
  sleep_force_a: assert property (state_ff == timer_clk_pkg::PWR_SLEEP |-> !procSel_ff && !oscRun_ff)
    else $error("Sleep without internal clock.");
  recover_len_a: assert property (state_ff == timer_clk_pkg::PWR_RUN && $past(state_ff) == timer_clk_pkg::PWR_RECOVER
    && !$past(wdReset) |-> $past(recCnt_ff) == 2'h2 && $past(rise32)) else $error("Recovery too short.");
  wd_flag_a: assert property (wdReset |=> wdFlag_ff && timerCfg_ff == `TIMER_CLK_RST && !irq_ff)
    else $error("Watchdog reset incomplete.");
  por_block_a: assert property (porFlag_ff && watchdogResetEvent && !wdFlag_ff |=> !wdFlag_ff)
    else $error("Watchdog not suppressed.");
  por_value_a: assert property ($past(sys_rst) |-> porFlag_ff && !wdFlag_ff && !sleep_ff && !stop_ff)
    else $error("Power-up status wrong.");
  boot_hold_a: assert property (state_ff == timer_clk_pkg::PWR_BOOT |=> hold_ff)
    else $error("Processor released during boot.");
  stop_hold_a: assert property (stop_ff |=> hold_ff) else $error("Stop did not hold.");
  gie_mirror_a: assert property (avs_read && !waitReq_ff && regIdx == `IDX_STATUS && avs_address[1:0] == 2'b00
    |-> readdata_ff[`STAT_GIE_BIT] == $past(globalIrqEnable)) else $error("Enable mirror wrong.");
  cap_off_a: assert property (timerCfg_ff.capSel == timer_clk_pkg::SRC_ALT |=> !capTick)
    else $error("Disabled capture clock ticked.");

  reload_cv: cover property (irq_ff);
  wake_cv: cover property (state_ff == timer_clk_pkg::PWR_RECOVER ##1 state_ff == timer_clk_pkg::PWR_RUN);
  wdr_cv: cover property (wdReset);
  tick_cv: cover property (tick1024_ff);
endmodule
`default_nettype wire

// ---- tb/core_model.sv ----
// Purpose: Far-side model: oscillator pins and the processor core's event lines.
// Assumes: Pins toggle freely; the bench requests core events by level.
// Notes: The slow pin rate is scaled far above its real figure to keep the run short; osc24 runs below 24 MHz.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core and oscillator model
module core_model (
  input wire logic ref_clk,
  input wire logic wdReq,
  input wire logic wakeReq,
  input wire logic gieReq,
  output var timer_clk_pkg::clk_pins_s clkPins,
  output logic watchdogResetEvent,
  output logic irqPending,
  output logic globalIrqEnable
);
  // Odd half periods keep the pins unrelated in phase to ref_clk.
  initial begin
    clkPins = '0;
    watchdogResetEvent = 1'b0;
    irqPending = 1'b0;
    globalIrqEnable = 1'b0;
  end
  always #51 clkPins.osc24 = ~clkPins.osc24;
  always #131 clkPins.ext = ~clkPins.ext;
  always #443 clkPins.slow = ~clkPins.slow;
  // Core lines change just after an edge, as the core's own flops would.
  always @(posedge ref_clk) begin
    watchdogResetEvent <= wdReq;
    irqPending <= wakeReq;
    globalIrqEnable <= gieReq;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the timer clock and reset control.
// Assumes: PorHoldCycles is shortened to 20 cycles.
// Notes: Rates are judged by counting edges in fixed windows; the 1024 us tick by capture ticks between two of its pulses.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  timer_clk_pkg::clk_pins_s clkPins;
  logic wdEvt, global_irq_enable, irqPend, capTick, intTick, tick1024, irq, clock_output_pin, procTick, hold, oscRun;
  logic [15:0] bootAddr;
  logic wdReq = 1'b0, wakeReq = 1'b0, gieReq = 1'b0, clr = 1'b0;
  logic [2:0] pinPrev = 3'h0;
  logic [2:0] pinNow;
  logic outPrev = 1'b0;
  logic [31:0] expQ [$];
  logic [31:0] expV;
  logic [7:0] v;
  int cnt [8];
  int num_errors = 0, cmp_count = 0, cyc = 0, n, i;
  int seed = 32'heda7;
  always #12.5 ref_clk = ~ref_clk;
  core_model model (.ref_clk(ref_clk), .wdReq(wdReq), .wakeReq(wakeReq), .gieReq(gieReq), .clkPins(clkPins),
    .watchdogResetEvent(wdEvt), .irqPending(irqPend), .globalIrqEnable(global_irq_enable));
  timer_clock_and_reset_control #(.PorHoldCycles(20)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clkPins(clkPins), .watchdogResetEvent(wdEvt), .globalIrqEnable(global_irq_enable), .irqPending(irqPend),
    .captureTimerClkTick(capTick), .intervalTimerClkTick(intTick), .intervalTick1024(tick1024),
    .intervalIrq(irq), .clockOutputPin(clock_output_pin), .processorClkTick(procTick), .processorHold(hold),
    .internalOscRun(oscRun), .bootAddr(bootAddr));
  assign pinNow = {clkPins.slow, clkPins.ext, clkPins.osc24};
  // Edge and pulse counters; a window starts when clr is pulsed.
  always @(posedge ref_clk) begin
    pinPrev <= pinNow;
    outPrev <= clock_output_pin;
    for (int k = 0; k < 8; k++) begin
      if (clr) cnt[k] <= 0;
    end
    if (!clr) begin
      for (int k = 0; k < 3; k++) cnt[k] <= cnt[k] + (pinNow[k] & ~pinPrev[k]);
      cnt[3] <= cnt[3] + capTick;
      cnt[4] <= cnt[4] + intTick;
      cnt[5] <= cnt[5] + irq;
      cnt[6] <= cnt[6] + (clock_output_pin & ~outPrev);
      cnt[7] <= cnt[7] + procTick;
    end
  end
  // Read results are matched against the oldest noted value.
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      expV = expQ.pop_front();
      cmp_count++;
      if (avs_readdata !== expV) begin
        $display("unexpected readdata expected %h seen %h", expV, avs_readdata);
        num_errors++;
      end
    end
  end
  // Hang guard: the whole run is near 82k cycles, two tick periods being most of it.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic bus(input logic rw, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= rw;
    avs_write <= ~rw;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'h1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    expQ.push_back({24'h0, d});
    bus(1'b1, idx, d);
  endtask
  task automatic chk(input string nm, input int e, input int got, input int tol);
    cmp_count++;
    if (got > e + tol || got < e - tol) begin
      $display("unexpected %s expected %0d seen %0d", nm, e, got);
      num_errors++;
    end
  endtask
  task automatic vchk(input string nm, input logic [15:0] e, input logic [15:0] got);
    cmp_count++;
    if (got !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, got);
      num_errors++;
    end
  endtask
  task automatic win(input int c);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic wd();
    @(posedge ref_clk);
    wdReq <= 1'b1;
    @(posedge ref_clk);
    wdReq <= 1'b0;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: reset state, clock trees, status bits, counter, sleep, stop.
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    n = 0;
    @(posedge ref_clk);
    while (hold === 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("holdCycles", 21, n, 1);
    vchk("bootAddr", 16'h0000, bootAddr);
    wd();
    rd(8'hff, 8'h10);
    rd(8'h31, 8'h8f);
    rd(8'h32, 8'h00);
    rd(8'h50, 8'h00);
    v = 8'($random(seed));
    wr(8'h31, v);
    rd(8'h31, v);
    win(1200);
    chk("procTicks", cnt[0] / 8, cnt[7], 2);
    for (i = 0; i < 4; i++) begin
      wr(8'h31, {i[1:0], 2'b00, i[1:0], 2'b00});
      win(1200);
      chk("capTicks", cnt[0] / (2 * i + 2), cnt[3], 2);
      chk("intTicks", cnt[0] / (i + 1), cnt[4], 2);
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h31, {2'b00, i[1:0], 2'b00, i[1:0]});
      wr(8'h32, {6'h00, i[1:0]});
      win(1200);
      chk("capTicks", (i == 3) ? 0 : cnt[i] / 2, cnt[3], (i == 3) ? 0 : 2);
      chk("intTicks", (i == 3) ? cnt[3] : cnt[i], cnt[4], 2);
      chk("clkOutRises", (i == 3) ? cnt[7] : cnt[i], cnt[6], 2);
    end
    gieReq <= 1'b1;
    rd(8'hff, 8'h90);
    wr(8'hff, 8'h00);
    rd(8'hff, 8'h80);
    wr(8'hff, 8'h30);
    rd(8'hff, 8'h80);
    wr(8'h31, 8'h00);
    wr(8'h40, 8'h03);
    wr(8'h41, 8'h00);
    win(1200);
    chk("irqCount", cnt[4] / 4, cnt[5], 2);
    wr(8'h40, 8'h05);
    rd(8'h40, 8'h03);
    win(1200);
    chk("irqCount", cnt[4] / 4, cnt[5], 2);
    wr(8'h41, 8'h00);
    rd(8'h40, 8'h05);
    win(1200);
    chk("irqCount", cnt[4] / 6, cnt[5], 2);
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h01);
    wr(8'hff, 8'h08);
    repeat (4) @(posedge ref_clk);
    vchk("oscRun", 16'h0, {15'h0, oscRun});
    vchk("hold", 16'h1, {15'h0, hold});
    @(posedge ref_clk);
    clr <= 1'b1;
    wakeReq <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    n = 0;
    while (hold === 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    wakeReq <= 1'b0;
    chk("wakeSlowEdges", 4, cnt[2], 1);
    vchk("oscRun", 16'h1, {15'h0, oscRun});
    rd(8'h30, 8'h00);
    rd(8'hff, 8'h80);
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h01);
    wr(8'hff, 8'h01);
    repeat (4) @(posedge ref_clk);
    vchk("hold", 16'h1, {15'h0, hold});
    wd();
    repeat (4) @(posedge ref_clk);
    vchk("hold", 16'h0, {15'h0, hold});
    rd(8'hff, 8'ha0);
    rd(8'h31, 8'h8f);
    rd(8'h30, 8'h00);
    wr(8'h31, 8'h00);
    while (tick1024 !== 1'b1) @(posedge ref_clk);
    n = 0;
    do begin
      @(posedge ref_clk);
      n += capTick;
    end while (tick1024 !== 1'b1);
    chk("capPer1024", 4096, n, 0);
    finish_test();
  end
endmodule
`default_nettype wire
